// ===== verilog/lpms_seq_regs.svh
`ifndef LPMS_SEQ_REGS_SVH
`define LPMS_SEQ_REGS_SVH

// register offsets (byte addresses)
`define LPMS_CTRL_OFS 8'h00
`define LPMS_IRQ_OFS 8'h04
`define LPMS_STAT_OFS 8'h08

// control register fields
`define LPMS_WSEL_BIT 0
`define LPMS_LOW_SPEED_ON_FLAG_BIT 1
`define LPMS_DIRECT_TRANSFER_FLAG_BIT 3
`define LPMS_FSEL_LSB 4
`define LPMS_TAMSK_BIT 6
`define LPMS_I0MSK_BIT 7
`define LPMS_CTRL_RST 8'h00

// request flag register fields
`define LPMS_TAF_BIT 0
`define LPMS_I0F_BIT 1

// time base: prescaler (3+5 bits) and timer a (8 bits) in sub ticks
`define LPMS_TB_W 16
`define LPMS_FTAP0 9
`define LPMS_FTAP1 11
`define LPMS_FTAP2 13

// timing
`define LPMS_CLK_NS 20
`define LPMS_SETTLE_NS 1000000
`define LPMS_SETTLE_CYC ((`LPMS_SETTLE_NS + `LPMS_CLK_NS - 1) / `LPMS_CLK_NS)

`endif

// ===== verilog/lpms_pkg.sv
package lpms_pkg;

  typedef enum logic [4:0] {
    LPMS_ACTIVE = 5'h01,
    LPMS_STOP = 5'h02,
    LPMS_WATCH = 5'h04,
    LPMS_SETTLE = 5'h08,
    LPMS_SUBACT = 5'h10
  } lpms_state_t;

  typedef enum logic [1:0] {
    LPMS_FRAME_SHORT = 2'h0,
    LPMS_FRAME_MID = 2'h1,
    LPMS_FRAME_LONG = 2'h2,
    LPMS_FRAME_RSVD = 2'h3
  } lpms_fsel_t;

endpackage : lpms_pkg

// ===== verilog/lpms_tb_if.sv
`timescale 1ns/1ns
interface lpms_tb_if;
  import lpms_pkg::*;
  lpms_fsel_t frame_sel;
  logic tb_clear;
  logic strobe;
  logic ta_ovf;
  logic sub_lvl;
  modport timebase (input frame_sel, input tb_clear,
                    output strobe, output ta_ovf, output sub_lvl);
  modport seq (output frame_sel, output tb_clear,
               input strobe, input ta_ovf, input sub_lvl);
endinterface : lpms_tb_if

// ===== verilog/lpms_frame.sv
`timescale 1ns/1ns
`include "lpms_seq_regs.svh"
module lpms_frame
  import lpms_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sub_osc_in,
  lpms_tb_if.timebase tb
);

  logic s1_q, s2_q, s3_q, lvl_q, lvl_d;
  logic [`LPMS_TB_W-1:0] cnt_q, cnt_d;
  logic strobe_q, strobe_d, ovf_q, ovf_d;
  logic tick;

  // pick the frame tap; the reserved code falls back to the short frame
  function automatic logic tap_hit(input lpms_fsel_t sel,
                                   input logic [`LPMS_TB_W-1:0] c);
    case (sel)
      LPMS_FRAME_MID: tap_hit = (c[`LPMS_FTAP1-1:0] == '0);
      LPMS_FRAME_LONG: tap_hit = (c[`LPMS_FTAP2-1:0] == '0);
      default: tap_hit = (c[`LPMS_FTAP0-1:0] == '0);
    endcase
  endfunction : tap_hit

  always_comb begin
    lvl_d = lvl_q;
    if (s2_q == s3_q) begin
      lvl_d = s3_q;
    end
    tick = lvl_d & ~lvl_q;
    cnt_d = cnt_q;
    strobe_d = 1'b0;
    ovf_d = 1'b0;
    if (tb.tb_clear) begin
      cnt_d = '0;
    end else if (tick) begin
      cnt_d = cnt_q + 1'b1;
      // R11 frame time base
      // R21 reserved frame code
      strobe_d = tap_hit(tb.frame_sel, cnt_d);
      // R12 overflow on strobe
      ovf_d = (cnt_d == '0);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
      cnt_q <= '0;
      strobe_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      s1_q <= sub_osc_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
      cnt_q <= cnt_d;
      strobe_q <= strobe_d;
      ovf_q <= ovf_d;
    end
  end

  assign tb.strobe = strobe_q;
  assign tb.ta_ovf = ovf_q;
  assign tb.sub_lvl = lvl_q;

  // R12 overflow with strobe
  ovf_on_strobe_a: assert property ( // R12
    @(posedge sys_clk) disable iff (rst) ovf_q |-> strobe_q)
    else $error("timer a overflow outside a frame strobe");

  // R21 reserved code as short
  rsvd_frame_a: assert property ( // R21
    @(posedge sys_clk) disable iff (rst)
    (strobe_q && $past(tb.frame_sel) == LPMS_FRAME_RSVD)
      |-> cnt_q[`LPMS_FTAP0-1:0] == '0)
    else $error("reserved frame code not on the short frame");

endmodule : lpms_frame

// ===== verilog/lpms_seq.sv
`timescale 1ns/1ns
`include "lpms_seq_regs.svh"
// Overview of operation
// R1 - stop instruction in active with watch select 0 enters stop, oscillator off
// R2 - only reset leaves stop; reset held one settle time by outside
// R3 - stop keeps ram; cpu working registers are not guaranteed afterwards
// R4 - watch from active stop with select 1, or stop/standby in subactive
// R5 - watch exits on reset or timer/ext_irq0_pin request; low speed flag picks mode
// R6 - wake to active takes one settle time after the frame-timed request
// R7 - stop/standby in subactive goes watch or active by the two flags
// R8 - direct transfer flag bit 3 set only in subactive, cleared in active
// R9 - direct flag with low speed 0 then stop/standby moves to active
// R10 - direct transfer lasts over one settle time, under frame plus settle
// R11 - watch and subactive keep time base running; three frame periods
// R12 - low power requests and timer overflow occur only at frame strobe
// R13 - reset input returns the device to active from any state
// R14 - stop/standby with master enable off and unmasked flag acts as no-op
// R15 - software clears or masks all requests before stop or standby
// R16 - stop/standby on a subactive strobe drops the pending requests; the code only blocks flags set at that strobe, earlier flags stay set
// R17 - ext_irq0_pin sampled once per frame; falling edge is high then low samples
// R18 - source holds ext_irq0_pin high then low longer than a frame each
// R19 - subactive clocks the cpu from the sub oscillator
// R20 - interrupt wake resumes in active; service only with master enable
// R21 - two-bit frame select; the fourth code falls back to the default
module lpms_seq
  import lpms_pkg::*;
#(
  parameter int SETTLE_CYC = `LPMS_SETTLE_CYC
)(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic stop_instr,
  input wire logic standby_instr,
  input wire logic irq_master_enable,
  input wire logic other_irq_pend,
  input wire logic ext_irq0_pin,
  input wire logic sub_osc_in,
  output logic sub_osc_out,
  output logic [4:0] mode,
  output logic sys_osc_en,
  output logic cpu_run,
  output logic cpu_clk_sub,
  output logic ram_hold,
  output logic wake_pulse,
  output logic irq_service,
  output logic instr_nop,
  output logic timer_a_irq_flag,
  output logic ext_irq0_flag
);

  localparam int CW = $clog2(SETTLE_CYC + 1);

  lpms_tb_if tb_if ();

  lpms_frame u_frame (
    .sys_clk(sys_clk),
    .rst(rst),
    .sub_osc_in(sub_osc_in),
    .tb(tb_if.timebase)
  );

  lpms_state_t st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic direct_transfer_flag_q, direct_transfer_flag_d, direct_q, direct_d;
  logic taf_q, taf_d, i0f_q, i0f_d;
  logic i0_s1_q, i0_s2_q, i0_s3_q, i0_lvl_q, i0_lvl_d;
  logic i0_smp_q, i0_smp_d;
  logic [31:0] rdata_q, rdata_d;
  logic osc_q, run_q, sub_q, hold_q, wake_q, svc_q, nop_q, sout_q;
  logic lowpow, instr, pend, nop, drop, ta_set, i0_set, i0_edge, wake_d;

  function automatic logic [31:0] zext8(input logic [7:0] v);
    zext8 = {24'h000000, v};
  endfunction : zext8

  assign tb_if.frame_sel = lpms_fsel_t'(ctrl_q[`LPMS_FSEL_LSB +: 2]);
  // R1 time base halted in stop
  assign tb_if.tb_clear = (st_q == LPMS_STOP);

  always_comb begin
    lowpow = (st_q == LPMS_WATCH) || (st_q == LPMS_SUBACT);
    instr = stop_instr | standby_instr;
    pend = (taf_q & ~ctrl_q[`LPMS_TAMSK_BIT])
         | (i0f_q & ~ctrl_q[`LPMS_I0MSK_BIT]) | other_irq_pend;
    // R14 cancelled low power instruction
    nop = instr & ~irq_master_enable & pend;
    // R16 drop requests on strobe
    drop = (st_q == LPMS_SUBACT) & instr & tb_if.strobe;
    i0_lvl_d = i0_lvl_q;
    if (i0_s2_q == i0_s3_q) begin
      i0_lvl_d = i0_s3_q;
    end
    i0_smp_d = i0_smp_q;
    if (lowpow) begin
      // R17 per frame sampling
      i0_edge = tb_if.strobe & i0_smp_q & ~i0_lvl_q;
      if (tb_if.strobe) begin
        i0_smp_d = i0_lvl_q;
      end
    end else begin
      i0_edge = i0_lvl_q & ~i0_lvl_d;
      i0_smp_d = i0_lvl_q;
    end
    // R12 requests raised at strobe
    ta_set = tb_if.ta_ovf & ~drop & (st_q != LPMS_STOP);
    i0_set = i0_edge & ~drop;
  end

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    direct_d = direct_q;
    wake_d = 1'b0;
    case (st_q)
      LPMS_ACTIVE: begin
        if (stop_instr && !nop) begin
          // R1 stop entry
          // R4 watch entry
          st_d = ctrl_q[`LPMS_WSEL_BIT] ? LPMS_WATCH : LPMS_STOP;
        end
      end
      LPMS_STOP: begin
        // R2 only reset leaves
        st_d = LPMS_STOP;
      end
      LPMS_WATCH: begin
        if (direct_q && tb_if.strobe) begin
          // R10 direct transfer waits one strobe
          st_d = LPMS_SETTLE;
          cnt_d = CW'(SETTLE_CYC - 1);
        end else if (ta_set || i0_set) begin
          // R5 wake by request
          if (ctrl_q[`LPMS_LOW_SPEED_ON_FLAG_BIT]) begin
            st_d = LPMS_SUBACT;
          end else begin
            // R6 settle before active
            st_d = LPMS_SETTLE;
            cnt_d = CW'(SETTLE_CYC - 1);
          end
        end
      end
      LPMS_SETTLE: begin
        if (cnt_q == '0) begin
          // R20 resume in active
          st_d = LPMS_ACTIVE;
          direct_d = 1'b0;
          wake_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      LPMS_SUBACT: begin
        if (instr && !nop) begin
          // R7 subactive exit choice
          // R9 direct transfer request
          st_d = LPMS_WATCH;
          direct_d = direct_transfer_flag_q & ~ctrl_q[`LPMS_LOW_SPEED_ON_FLAG_BIT];
        end
      end
      default: st_d = LPMS_ACTIVE;
    endcase
  end

  always_comb begin
    ctrl_d = ctrl_q;
    direct_transfer_flag_d = direct_transfer_flag_q;
    taf_d = taf_q;
    i0f_d = i0f_q;
    rdata_d = 32'h00000000;
    if (wr && addr == `LPMS_CTRL_OFS) begin
      ctrl_d = wdata[7:0];
      ctrl_d[`LPMS_DIRECT_TRANSFER_FLAG_BIT] = 1'b0;
      // R8 settable only in subactive
      if (!wdata[`LPMS_DIRECT_TRANSFER_FLAG_BIT] || st_q == LPMS_SUBACT) begin
        direct_transfer_flag_d = wdata[`LPMS_DIRECT_TRANSFER_FLAG_BIT];
      end
    end else if (wr && addr == `LPMS_IRQ_OFS) begin
      taf_d = taf_q & ~wdata[`LPMS_TAF_BIT];
      i0f_d = i0f_q & ~wdata[`LPMS_I0F_BIT];
    end
    // R8 cleared on entry to active
    if (st_d == LPMS_ACTIVE) begin
      direct_transfer_flag_d = 1'b0;
    end
    // hardware set wins over a same-cycle clear
    if (ta_set) begin
      taf_d = 1'b1;
    end
    if (i0_set) begin
      i0f_d = 1'b1;
    end
    if (rd && addr == `LPMS_CTRL_OFS) begin
      rdata_d = zext8(ctrl_q | ({7'h00, direct_transfer_flag_q} << `LPMS_DIRECT_TRANSFER_FLAG_BIT));
    end else if (rd && addr == `LPMS_IRQ_OFS) begin
      rdata_d = zext8({6'h00, i0f_q, taf_q});
    end else if (rd && addr == `LPMS_STAT_OFS) begin
      rdata_d = zext8({3'h0, st_q});
    end
  end

  always_ff @(posedge sys_clk) begin
    // R13 reset from any state
    if (rst) begin
      st_q <= LPMS_ACTIVE;
      cnt_q <= '0;
      direct_q <= 1'b0;
      ctrl_q <= `LPMS_CTRL_RST;
      direct_transfer_flag_q <= 1'b0;
      taf_q <= 1'b0;
      i0f_q <= 1'b0;
      i0_s1_q <= 1'b1;
      i0_s2_q <= 1'b1;
      i0_s3_q <= 1'b1;
      i0_lvl_q <= 1'b1;
      i0_smp_q <= 1'b1;
      rdata_q <= 32'h00000000;
      osc_q <= 1'b1;
      run_q <= 1'b1;
      sub_q <= 1'b0;
      hold_q <= 1'b0;
      wake_q <= 1'b0;
      svc_q <= 1'b0;
      nop_q <= 1'b0;
      sout_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      direct_q <= direct_d;
      ctrl_q <= ctrl_d;
      direct_transfer_flag_q <= direct_transfer_flag_d;
      taf_q <= taf_d;
      i0f_q <= i0f_d;
      i0_s1_q <= ext_irq0_pin;
      i0_s2_q <= i0_s1_q;
      i0_s3_q <= i0_s2_q;
      i0_lvl_q <= i0_lvl_d;
      i0_smp_q <= i0_smp_d;
      rdata_q <= rdata_d;
      osc_q <= (st_d == LPMS_ACTIVE) || (st_d == LPMS_SETTLE);
      run_q <= (st_d == LPMS_ACTIVE) || (st_d == LPMS_SUBACT);
      // R19 cpu on sub oscillator
      sub_q <= (st_d == LPMS_SUBACT);
      // R3 ram kept in stop and watch
      hold_q <= (st_d == LPMS_STOP) || (st_d == LPMS_WATCH);
      wake_q <= wake_d;
      // R20 service only when enabled
      svc_q <= wake_d & irq_master_enable & pend;
      nop_q <= nop && (st_q == LPMS_ACTIVE || st_q == LPMS_SUBACT);
      sout_q <= ~tb_if.sub_lvl;
    end
  end

  assign rdata = rdata_q;
  assign mode = st_q;
  assign sys_osc_en = osc_q;
  assign cpu_run = run_q;
  assign cpu_clk_sub = sub_q;
  assign ram_hold = hold_q;
  assign wake_pulse = wake_q;
  assign irq_service = svc_q;
  assign instr_nop = nop_q;
  assign timer_a_irq_flag = taf_q;
  assign ext_irq0_flag = i0f_q;
  assign sub_osc_out = sout_q;

  // R1 stop entry check
  stop_entry_a: assert property ( // R1
    @(posedge sys_clk) disable iff (rst)
    (st_q == LPMS_ACTIVE && stop_instr && !nop && !ctrl_q[`LPMS_WSEL_BIT])
      |=> (st_q == LPMS_STOP) && !sys_osc_en)
    else $error("stop instruction did not halt the oscillator");

  // R2 stop held check
  stop_hold_a: assert property ( // R2
    @(posedge sys_clk) disable iff (rst)
    st_q == LPMS_STOP |=> st_q == LPMS_STOP)
    else $error("stop left without reset");

  // R4 watch entry check
  watch_entry_a: assert property ( // R4
    @(posedge sys_clk) disable iff (rst)
    (st_q == LPMS_ACTIVE && stop_instr && !nop && ctrl_q[`LPMS_WSEL_BIT])
      |=> st_q == LPMS_WATCH && ram_hold)
    else $error("watch not entered");

  // R5 subactive wake check
  sub_wake_a: assert property ( // R5
    @(posedge sys_clk) disable iff (rst)
    (st_q == LPMS_WATCH && !direct_q && (ta_set || i0_set)
      && ctrl_q[`LPMS_LOW_SPEED_ON_FLAG_BIT])
      |=> st_q == LPMS_SUBACT && cpu_clk_sub)
    else $error("request did not wake to subactive");

  // R6 settle end check
  settle_end_a: assert property ( // R6
    @(posedge sys_clk) disable iff (rst)
    (st_q == LPMS_SETTLE && cnt_q == '0)
      |=> st_q == LPMS_ACTIVE && wake_pulse ##1 !wake_pulse)
    else $error("settle did not end in active");

  // R8 direct flag check
  direct_transfer_flag_clear_a: assert property ( // R8
    @(posedge sys_clk) disable iff (rst)
    st_q == LPMS_ACTIVE |-> !direct_transfer_flag_q)
    else $error("direct flag set while active");

  // R14 cancelled instruction check
  nop_stay_a: assert property ( // R14
    @(posedge sys_clk) disable iff (rst)
    (st_q == LPMS_ACTIVE && nop) |=> st_q == LPMS_ACTIVE && instr_nop)
    else $error("blocked instruction changed mode");

  // R16 dropped request check
  drop_req_a: assert property ( // R16
    @(posedge sys_clk) disable iff (rst)
    (drop && !taf_q && !i0f_q) |=> !taf_q && !i0f_q)
    else $error("request kept on a strobe-time instruction");

endmodule : lpms_seq

// ===== tb/lpms_far.sv
`timescale 1ns/1ns
module lpms_far #(
  parameter int SUB_HALF_NS = 80,
  parameter int HOLD_CYC = 4608
)(
  input wire logic sys_clk,
  output logic sub_osc_in,
  output logic ext_irq0_pin
);
  initial sub_osc_in = 1'b0;
  initial ext_irq0_pin = 1'b1;
  // crystal runs free; sped up so a frame fits in a short run
  always #(SUB_HALF_NS) sub_osc_in = ~sub_osc_in;
  task automatic ext_irq0_pin_edge;
    repeat (HOLD_CYC) @(posedge sys_clk);
    ext_irq0_pin <= 1'b0;
    repeat (HOLD_CYC) @(posedge sys_clk);
    ext_irq0_pin <= 1'b1;
  endtask : ext_irq0_pin_edge
endmodule : lpms_far

// ===== tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  import lpms_pkg::*;
  localparam int SETTLE = 8;
  // 2^9 sub ticks of 8 system cycles each
  localparam int FRAME = 4096;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic stop_instr = 1'b0;
  logic standby_instr = 1'b0;
  logic irq_master_enable = 1'b1;
  logic other_irq_pend = 1'b0;
  logic ext_irq0_pin;
  logic sub_osc_in;
  logic [31:0] rdata;
  logic [4:0] mode;
  logic sys_osc_en, cpu_run, cpu_clk_sub, ram_hold;
  logic wake_pulse, irq_service, instr_nop;
  logic sub_osc_out, timer_a_irq_flag, ext_irq0_flag;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int settle_cnt = 0;
  int n;
  integer seed = 32'h0CF21530;
  logic rd_seen = 1'b0;
  logic [31:0] rd_q[$];
  logic wk_q[$];

  always #10 sys_clk = ~sys_clk;

  lpms_seq #(.SETTLE_CYC(SETTLE)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .stop_instr(stop_instr),
    .standby_instr(standby_instr), .irq_master_enable(irq_master_enable),
    .other_irq_pend(other_irq_pend), .ext_irq0_pin(ext_irq0_pin),
    .sub_osc_in(sub_osc_in), .sub_osc_out(sub_osc_out), .mode(mode),
    .sys_osc_en(sys_osc_en), .cpu_run(cpu_run), .cpu_clk_sub(cpu_clk_sub),
    .ram_hold(ram_hold), .wake_pulse(wake_pulse), .irq_service(irq_service),
    .instr_nop(instr_nop), .timer_a_irq_flag(timer_a_irq_flag),
    .ext_irq0_flag(ext_irq0_flag)
  );

  lpms_far #(.SUB_HALF_NS(80), .HOLD_CYC(FRAME + 512)) far_u (
    .sys_clk(sys_clk), .sub_osc_in(sub_osc_in), .ext_irq0_pin(ext_irq0_pin)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  // upper data bits are random; the block must ignore them
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    logic [31:0] r;
    r = $random(seed);
    @(posedge sys_clk);
    addr <= a;
    wdata <= {r[31:8], v};
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
  endtask : reg_rd

  task automatic pulse(input logic sb);
    @(posedge sys_clk);
    if (sb) standby_instr <= 1'b1;
    else stop_instr <= 1'b1;
    @(posedge sys_clk);
    standby_instr <= 1'b0;
    stop_instr <= 1'b0;
    // outputs are read one edge after the instruction, once settled
    @(posedge sys_clk);
  endtask : pulse

  task automatic wait_mode(input logic [4:0] m, input int lim, output int c);
    c = 0;
    while (mode !== m && c < lim) begin
      @(posedge sys_clk);
      c++;
    end
    chk(mode, m);
  endtask : wait_mode

  // read data stand only in the cycle after the strobe
  always @(posedge sys_clk) begin
    rd_seen <= rd;
    if (rd_seen && rd_q.size() > 0) chk(rdata, rd_q.pop_front());
    settle_cnt <= (mode === LPMS_SETTLE) ? settle_cnt + 1 : 0;
    if (wake_pulse === 1'b1) begin
      chk(irq_service, wk_q.size() ? wk_q.pop_front() : 1'bx);
      chk(settle_cnt, SETTLE);
    end
    cycles <= cycles + 1;
    if (cycles > 90000) begin
      errors++;
      stop_test();
    end
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    reg_rd(8'h08, 32'h01);
    reg_rd(8'h00, 32'h00);
    reg_rd(8'h04, 32'h00);
    reg_rd(8'h0C, 32'h00);
    reg_wr(8'h00, 8'h09);
    reg_rd(8'h00, 32'h01);
    irq_master_enable <= 1'b0;
    other_irq_pend <= 1'b1;
    pulse(1'b0);
    chk(instr_nop, 1'b1);
    chk(mode, LPMS_ACTIVE);
    other_irq_pend <= 1'b0;
    irq_master_enable <= 1'b1;
    reg_wr(8'h04, 8'h03);
    pulse(1'b0);
    chk(mode, LPMS_WATCH);
    chk({cpu_run, sys_osc_en, ram_hold}, 3'h1);
    wk_q.push_back(1'b1);
    far_u.ext_irq0_pin_edge();
    wait_mode(LPMS_ACTIVE, FRAME, n);
    chk({timer_a_irq_flag, ext_irq0_flag}, 2'h1);
    reg_rd(8'h04, 32'h02);
    reg_wr(8'h04, 8'h03);
    reg_wr(8'h00, 8'h33);
    pulse(1'b0);
    chk(mode, LPMS_WATCH);
    far_u.ext_irq0_pin_edge();
    wait_mode(LPMS_SUBACT, FRAME, n);
    chk({cpu_clk_sub, cpu_run}, 2'h3);
    reg_wr(8'h04, 8'h03);
    irq_master_enable <= 1'b0;
    reg_wr(8'h00, 8'h38);
    reg_rd(8'h00, 32'h38);
    wk_q.push_back(1'b0);
    pulse(1'b1);
    chk(mode, LPMS_WATCH);
    wait_mode(LPMS_ACTIVE, FRAME + SETTLE + 4, n);
    reg_rd(8'h00, 32'h30);
    irq_master_enable <= 1'b1;
    reg_wr(8'h00, 8'h00);
    pulse(1'b0);
    chk(mode, LPMS_STOP);
    chk({sys_osc_en, ram_hold}, 2'h1);
    far_u.ext_irq0_pin_edge();
    chk(mode, LPMS_STOP);
    // reset held beyond the settle time
    rst <= 1'b1;
    repeat (12) @(posedge sys_clk);
    chk(sub_osc_out, 1'b1);
    rst <= 1'b0;
    reg_rd(8'h08, 32'h01);
    repeat (3) @(posedge sys_clk);
    stop_test();
  end
endmodule : testbench
